// ==== imvs_pkg.sv ====
package imvs_pkg;
  // ****************************************
  // bus map
  // ****************************************
  localparam logic [11:0] ADDR_EXPANDER_CONTROL = 12'hce0; // expander_control
  localparam logic [11:0] ADDR_EXT_IFACE_CONFIG = 12'hb34; // ext_iface_config_two
  localparam logic [11:0] ADDR_STATUS_ONE       = 12'hd80; // status_register_one mirror
  localparam logic [11:0] ADDR_STATUS_ONE_SET   = 12'hd84; // bit set strobe
  localparam logic [11:0] ADDR_STATUS_ONE_CLR   = 12'hd88; // bit clear strobe
  localparam logic [11:0] ADDR_GROUP_FLAG_BASE  = 12'hc00; // 12 flag words
  localparam logic [11:0] ADDR_GROUP_EN_BASE    = 12'hc40; // 12 enable words
  localparam logic [11:0] ADDR_IRQ_STATUS       = 12'hd90; // sticky events
  localparam logic [11:0] ADDR_IRQ_MASK         = 12'hd94; // event mask
  localparam logic [11:0] ADDR_VECTOR_BASE      = 12'h400; // 256 words of vector ram
  // ****************************************
  // sizes and fields
  // ****************************************
  localparam int NUM_GROUPS = 12;
  localparam int GROUP_SIZE = 8;
  localparam int NUM_INPUTS = 96;
  localparam int VEC_DEPTH  = 256;
  localparam int VEC_WIDTH  = 16;
  localparam int BIT_VECTOR_MAP_BIT   = 3;   // vector_map_bit
  localparam int BIT_SWAP   = 11;  // ram_swap_bit
  localparam int BIT_ADDRESSING_MODE_BIT  = 7;   // addressing_mode_bit
  localparam int BIT_OBJ    = 9;   // object_mode_bit
  localparam int BIT_BOOT   = 8;   // boot_select_bit
  localparam int BIT_ENABLE = 0;   // expander_enable_bit
  localparam logic [15:0] ST1_RESET = 16'h0808; // map and swap set, modes clear
  // wired slots per group, a one marks a peripheral source
  localparam logic [95:0] WIRED_SLOTS = {
    8'h00, 8'h00, 8'h00, 8'h3f, 8'h00, 8'h00,
    8'h33, 8'h7f, 8'h7f, 8'h7f, 8'h7f, 8'hfb};
  // ****************************************
  // enumerations
  // ****************************************
  typedef enum logic [2:0] {
    REGION_RAM_FIRST, REGION_RAM_SECOND, REGION_BOOT_ROM,
    REGION_EXT_ZONE, REGION_EXPANDER} imvs_region_t;
  typedef enum logic [1:0] {
    MODE_OBJECT_COMPAT, MODE_NATIVE, MODE_LEGACY_SOURCE, MODE_UNDEFINED} imvs_mode_t;
  localparam logic [21:0] LOW_BASE  = 22'h000000;
  localparam logic [21:0] HIGH_BASE = 22'h3fffc0;
  localparam logic [21:0] PIE_BASE  = 22'h000d00;
endpackage : imvs_pkg

// ==== imvs_top.sv ====
`timescale 1ns/10ps
`default_nettype none
// Overview of operation
// - twelve groups of eight fold onto lines
// - only 45 slots have peripheral sources
// - reserved slots still fire by software flag
// - vectors fetched from one of five regions
// - map, swap, enable, boot bits pick region
// - vector map bit 3, resets to one
// - ram swap bit 11, resets to one
// - boot select bit 8 of config
// - no external iface means pin tied low
// - expander enable bit 0, resets clear
// - reset vector always from high region
// - pin captured at reset, then software only
// - mode decoded from object and addressing bits
// - position one highest within a group
// - vector table is 256x16 undefined ram
module imvs_top
  import imvs_pkg::*;
#(
  parameter bit HAS_EXT_IFACE = 1'b1
) (
  // clock and reset
  input  wire logic                      clk,
  input  wire logic                      reset,
  // apb slave
  input  wire logic                      psel,
  input  wire logic                      penable,
  input  wire logic                      pwrite,
  input  wire logic [11:0]               paddr,
  input  wire logic [31:0]               pwdata,
  output logic      [31:0]               prdata,
  output logic                           pready,
  output logic                           pslverr,
  // peripheral sources and boot pin
  input  wire logic [95:0]               group_slot_input,
  input  wire logic                      boot_source_pin,
  // cpu side
  output logic      [11:0]               cpu_int_line,
  output logic      [11:0][2:0]          group_winner,
  output logic      [21:0]               vector_base,
  output logic      [2:0]                vector_region,
  output logic      [1:0]                compat_mode,
  output logic                           irq
);
  import imvs_pkg::*;

  // ****************************************
  // input synchronisers
  // ****************************************
  // the first stage is read by nothing but the second
  logic [95:0] src_meta;       // first stage, read only by src_sync
  logic [95:0] src_sync;       // usable source levels
  logic [95:0] src_prev;       // for rising edge detect
  logic        pin_meta;       // first stage of boot pin
  logic        pin_sync;       // usable boot pin level
  logic        in_reset_d;     // one cycle after release flag

  // the pin is tied low when the variant lacks the external interface
  // so that variant always boots with the boot bit clear
  wire pin_eff = HAS_EXT_IFACE ? pin_sync : 1'b0;

  // two flops on every foreign level; no reset, so the chain keeps tracking the
  // pins while reset is held and the edge detector starts at the true level
  // (a reset value here could fake an edge on the first cycle after release)
  always_ff @(posedge clk) begin
    src_meta <= group_slot_input;
    src_sync <= src_meta;
    src_prev <= src_sync;
    pin_meta <= boot_source_pin;
    pin_sync <= pin_meta;
  end

  // ****************************************
  // registers
  // ****************************************
  // architectural state seen by software
  logic [15:0] status_one;     // mirror of status_register_one
  logic        boot_select;    // boot_select_bit
  logic        expander_en;    // expander_enable_bit
  logic [95:0] flags;          // group_flag_register bits
  logic [95:0] enables;        // group enable bits
  logic [1:0]  irq_status;     // sticky: line rise, region change
  logic [1:0]  irq_mask;       // gate onto irq
  logic [VEC_WIDTH-1:0] vec_ram [VEC_DEPTH]; // no reset, contents undefined

  // ****************************************
  // bus decode
  // ****************************************
  // a write lands only on the answer edge, where the master samples pready high;
  // this also keeps a flag rewrite from running twice in one access
  wire        wr_stb    = psel & penable & pwrite & pready;
  // reads are looked up on the waiting edge so the data stand with pready
  wire        rd_stb    = psel & penable & ~pwrite & ~pready;
  // word decode, the two low address bits are ignored
  wire [11:0] word_addr = {paddr[11:2], 2'b00};
  wire        hit_ctrl  = (word_addr == ADDR_EXPANDER_CONTROL);
  wire        hit_cfg   = (word_addr == ADDR_EXT_IFACE_CONFIG);
  wire        hit_st1   = (word_addr == ADDR_STATUS_ONE);
  wire        hit_set   = (word_addr == ADDR_STATUS_ONE_SET);
  wire        hit_clr   = (word_addr == ADDR_STATUS_ONE_CLR);
  wire        hit_ist   = (word_addr == ADDR_IRQ_STATUS);
  wire        hit_imsk  = (word_addr == ADDR_IRQ_MASK);
  // twelve flag words and twelve enable words, one byte used in each
  wire        hit_flag  = (word_addr >= ADDR_GROUP_FLAG_BASE) &&
                          (word_addr < ADDR_GROUP_FLAG_BASE + 12'h030);
  wire        hit_en    = (word_addr >= ADDR_GROUP_EN_BASE) &&
                          (word_addr < ADDR_GROUP_EN_BASE + 12'h030);
  // 256 words of vector ram
  wire        hit_vec   = (word_addr >= ADDR_VECTOR_BASE) &&
                          (word_addr < ADDR_VECTOR_BASE + 12'h400);
  // group index from the word offset; flag and enable windows share the low bits
  wire [3:0]  grp_idx   = hit_flag ? 4'(paddr[5:2]) : 4'(paddr[5:2] - 4'h0);
  // bit offset of the group byte; seven bits wide, since group 11 starts at bit 88
  // and a four bit product would wrap onto a lower group
  wire [6:0]  grp_shift = {grp_idx, 3'b000};
  // one vector ram word per bus word
  wire [7:0]  vec_idx   = paddr[9:2];
  // any other address answers with an error and is ignored
  wire        hit_any   = hit_ctrl | hit_cfg | hit_st1 | hit_set | hit_clr |
                          hit_ist | hit_imsk | hit_flag | hit_en | hit_vec;

  // slot rising edges, gated to wired slots; reserved slots get no hardware source
  // a level held high sets its flag once; software clears it
  wire [95:0] hw_event  = src_sync & ~src_prev & WIRED_SLOTS;

  // per-group flag write mask: a software one sets any slot, reserved ones too
  wire [95:0] sw_set    = (wr_stb & hit_flag) ?
                          (96'(pwdata[7:0]) << grp_shift) : 96'h0;
  // the other eleven groups keep their flags
  wire [95:0] sw_keep   = (wr_stb & hit_flag) ?
                          ~(96'(8'hff) << grp_shift) : {96{1'b1}};
  // a hardware event in the same cycle as a rewrite survives
  wire [95:0] next_flags = (flags & sw_keep) | sw_set | hw_event;
  // enables are plain read/write bytes, one per group
  wire [95:0] next_enables = (wr_stb & hit_en) ?
      ((enables & ~(96'(8'hff) << grp_shift)) |
       (96'(pwdata[7:0]) << grp_shift)) : enables;

  // ****************************************
  // status register one and mode bits
  // ****************************************
  // set/clear strobes stand in for the dedicated bit instructions
  // a plain write replaces all sixteen bits
  wire [15:0] next_status_one =
      (wr_stb & hit_st1) ? pwdata[15:0] :
      (wr_stb & hit_set) ? (status_one | pwdata[15:0]) :
      (wr_stb & hit_clr) ? (status_one & ~pwdata[15:0]) : status_one;

  // software state; flags and enables clear so nothing is pending after reset
  // in_reset_d marks the first edge after release for the boot capture
  always_ff @(posedge clk) begin
    if (reset) begin
      status_one <= ST1_RESET;
      expander_en <= 1'b0;
      flags      <= 96'h0;
      enables    <= 96'h0;
      in_reset_d <= 1'b1;
    end else begin
      status_one <= next_status_one;
      flags      <= next_flags;
      enables    <= next_enables;
      in_reset_d <= 1'b0;
      if (wr_stb & hit_ctrl) begin
        expander_en <= pwdata[BIT_ENABLE];
      end
    end
  end

  // boot bit: a reset constant would lose the pin, so it is loaded from the pin
  // on the first edge after release; the pin is ignored from then on
  // no bus write can land on that edge, so the capture never races software
  always_ff @(posedge clk) begin
    if (reset) begin
      boot_select <= 1'b0;
    end else if (in_reset_d) begin
      boot_select <= pin_eff;
    end else if (wr_stb & hit_cfg) begin
      boot_select <= pwdata[BIT_BOOT];
    end
  end

  // vector ram, usable as plain storage while the expander is off
  // one write port from the bus; reads go through the bus mux
  always_ff @(posedge clk) begin
    if (wr_stb & hit_vec) begin
      vec_ram[vec_idx] <= pwdata[15:0];
    end
  end

  // ****************************************
  // group folding and priority
  // ****************************************
  // lowest set bit wins, i.e. position one first
  // an empty group returns zero; the line, not the winner, says it is valid
  function automatic logic [2:0] first_set(input logic [7:0] v);
    logic [2:0] r;
    r = 3'd0;
    for (int i = GROUP_SIZE - 1; i >= 0; i--) begin
      if (v[i]) begin
        r = 3'(i);
      end
    end
    return r;
  endfunction : first_set

  // line and winner per group, registered below
  logic [11:0]      next_lines;
  logic [11:0][2:0] next_winner;
  // every group is presented at once, the cpu arbitrates across groups
  always_comb begin
    for (int g = 0; g < NUM_GROUPS; g++) begin
      next_lines[g]  = |(flags[g*GROUP_SIZE +: GROUP_SIZE] &
                         enables[g*GROUP_SIZE +: GROUP_SIZE]);
      next_winner[g] = first_set(flags[g*GROUP_SIZE +: GROUP_SIZE] &
                                 enables[g*GROUP_SIZE +: GROUP_SIZE]);
    end
  end

  // ****************************************
  // vector region selection
  // ****************************************
  // map bit low picks low ram, then the enable, then the boot bit
  wire vector_map_bit = status_one[BIT_VECTOR_MAP_BIT];
  wire swap = status_one[BIT_SWAP];
  // swap clear is a test-only mapping; software is expected to keep it set
  wire [2:0] next_region =
      !vector_map_bit        ? (swap ? 3'(REGION_RAM_SECOND) : 3'(REGION_RAM_FIRST)) :
      expander_en  ? 3'(REGION_EXPANDER) :
      boot_select  ? 3'(REGION_EXT_ZONE) : 3'(REGION_BOOT_ROM);
  // reset window forces the high region, chosen by pin level alone
  // whatever software wrote before the reset does not count here
  wire [2:0] sel_region = in_reset_d ?
      (pin_eff ? 3'(REGION_EXT_ZONE) : 3'(REGION_BOOT_ROM)) : next_region;
  // base address of the chosen region
  wire [21:0] next_base =
      (sel_region == 3'(REGION_EXPANDER)) ? PIE_BASE :
      (sel_region == 3'(REGION_RAM_FIRST) ||
       sel_region == 3'(REGION_RAM_SECOND)) ? LOW_BASE : HIGH_BASE;
  // mode decode; object clear with addressing set has no defined mode
  wire [1:0] obj_am = {status_one[BIT_OBJ], status_one[BIT_ADDRESSING_MODE_BIT]};
  wire [1:0] next_mode =
      (obj_am == 2'b10) ? 2'(MODE_NATIVE) :
      (obj_am == 2'b11) ? 2'(MODE_LEGACY_SOURCE) :
      (obj_am == 2'b00) ? 2'(MODE_OBJECT_COMPAT) : 2'(MODE_UNDEFINED);

  // ****************************************
  // interrupt status and read mux
  // ****************************************
  // events: any cpu line rising, or the region moving outside the reset window
  wire [1:0] ev_now = {(next_region != vector_region) & ~in_reset_d,
                       |(next_lines & ~cpu_int_line)};
  // write one to clear; an event in the same cycle still sets
  wire [1:0] w1c    = (wr_stb & hit_ist) ? pwdata[1:0] : 2'b00;
  // config readback holds only the boot bit
  wire [15:0] cfg_rd  = 16'(boot_select) << BIT_BOOT;
  // read mux, unmapped reads give zero
  wire [31:0] rd_mux =
      hit_ctrl ? {16'h0, 15'h0, expander_en} :
      hit_cfg  ? {16'h0, cfg_rd} :
      (hit_st1 | hit_set | hit_clr) ? {16'h0, status_one} :
      hit_ist  ? {30'h0, irq_status} :
      hit_imsk ? {30'h0, irq_mask} :
      hit_flag ? {24'h0, 8'(flags >> grp_shift)} :
      hit_en   ? {24'h0, 8'(enables >> grp_shift)} :
      hit_vec  ? {16'h0, vec_ram[vec_idx]} : 32'h0;

  // outputs all from flops; set beats clear on the sticky bits
  // pready is a one-cycle pulse: exactly one wait state per access
  // prdata returns to zero outside an answer so stale data never stand
  always_ff @(posedge clk) begin
    if (reset) begin
      irq_status    <= 2'b00;
      irq_mask      <= 2'b00;
      irq           <= 1'b0;
      cpu_int_line  <= 12'h0;
      group_winner  <= '0;
      vector_region <= 3'(REGION_BOOT_ROM);
      vector_base   <= HIGH_BASE;
      compat_mode   <= 2'(MODE_OBJECT_COMPAT);
      prdata        <= 32'h0;
      pready        <= 1'b0;
      pslverr       <= 1'b0;
    end else begin
      irq_status    <= (irq_status & ~w1c) | ev_now;
      if (wr_stb & hit_imsk) begin
        irq_mask <= pwdata[1:0];
      end
      irq           <= |(irq_status & irq_mask);
      cpu_int_line  <= next_lines;
      group_winner  <= next_winner;
      vector_region <= sel_region;
      vector_base   <= next_base;
      compat_mode   <= next_mode;
      prdata        <= rd_stb ? rd_mux : 32'h0;
      pready        <= psel & penable & ~pready;
      pslverr       <= psel & penable & ~pready & ~hit_any;
    end
  end
endmodule : imvs_top
`default_nettype wire

// ==== imvs_monitor.sv ====
`timescale 1ns/10ps
`default_nettype none
module imvs_monitor
  import imvs_pkg::*;
(
  // clock and reset
  input wire logic        clk,
  input wire logic        reset,
  // bus handshake
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic [31:0] prdata,
  // vector map
  input wire logic [21:0] vector_base,
  input wire logic [2:0]  vector_region
);
  // ************************************
  // bus and vector map checks
  // ************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  // access phase still waiting, then the one-cycle answer
  sequence s_wait; psel && penable && !pready; endsequence
  sequence s_answer; pready ##1 !pready; endsequence
  chk_one_wait: assert property (s_wait |=> s_answer)
    else $error("bus answer not after one wait state");
  chk_err_ready: assert property (pslverr |-> pready)
    else $error("error flag without ready");
  chk_idle_zero: assert property (!pready |-> prdata == 32'h0)
    else $error("read data outside an answer");
  chk_high_base: assert property (
    vector_region inside {REGION_BOOT_ROM, REGION_EXT_ZONE} |-> vector_base == HIGH_BASE)
    else $error("high region base wrong");
  chk_table_base: assert property (
    vector_region == REGION_EXPANDER |-> vector_base == PIE_BASE)
    else $error("expander table base wrong");
  chk_low_base: assert property (
    vector_region inside {REGION_RAM_FIRST, REGION_RAM_SECOND} |-> vector_base == LOW_BASE)
    else $error("low ram base wrong");
  chk_region_legal: assert property (vector_region <= 3'h4)
    else $error("region code out of range");
  // reset itself is the cause here, so this one is never disabled
  chk_reset_vector: assert property (@(posedge clk) disable iff (1'b0) reset |=>
    vector_region == REGION_BOOT_ROM && vector_base == HIGH_BASE)
    else $error("reset vector not in high region");
endmodule : imvs_monitor
bind imvs_top imvs_monitor i_mon (.clk(clk), .reset(reset), .psel(psel), .penable(penable),
  .pready(pready), .pslverr(pslverr), .prdata(prdata), .vector_base(vector_base),
  .vector_region(vector_region));
`default_nettype wire

// ==== imvs_cpu_model.sv ====
`timescale 1ns/10ps
`default_nettype none
module imvs_cpu_model
  import imvs_pkg::*;
(
  // clock and reset
  input  wire logic             clk,
  input  wire logic             reset,
  // lines and map from the expander
  input  wire logic [11:0]      cpu_int_line,
  input  wire logic [11:0][2:0] group_winner,
  input  wire logic [21:0]      vector_base,
  // vector address the core would fetch
  output logic      [21:0]      fetch_addr
);
  // ************************************
  // core side vector fetch
  // ************************************
  // lowest line wins between groups; last assignment in the loop wins
  always_ff @(posedge clk) begin
    if (reset) begin
      fetch_addr <= 22'h0;
    end else begin
      fetch_addr <= 22'h0;
      for (int g = 11; g >= 0; g--) begin
        if (cpu_int_line[g]) begin // two words per vector entry
          fetch_addr <= vector_base + 22'h40 + 22'(g * 16) + 22'({group_winner[g], 1'b0});
        end
      end
    end
  end
endmodule : imvs_cpu_model
`default_nettype wire

// ==== interrupt_mux_vector_select_tb.sv ====
`timescale 1ns/10ps
`default_nettype none
module interrupt_mux_vector_select_tb;
  import imvs_pkg::*;
  // ************************************
  // stimulus and bus tasks
  // ************************************
  logic             clk = 1'b0;
  logic             reset = 1'b1;
  logic             psel = 1'b0;
  logic             penable = 1'b0;
  logic             pwrite = 1'b0;
  logic [11:0]      paddr = 12'h0;
  logic [31:0]      pwdata = 32'h0;
  logic [95:0]      slot_in = 96'h0;
  logic             boot_pin = 1'b1;  // held high through reset
  logic [31:0]      prdata, rd;
  logic             pready, pslverr, er, irq;
  logic [11:0]      line;
  logic [11:0][2:0] winner;
  logic [21:0]      vbase, fetch;
  logic [2:0]       region, region_nx;
  logic [1:0]       mode;
  int               err_total = 0;
  int               n_tests = 0;
  always #5 clk = ~clk;
  task automatic conclude;
    $display("comparisons %0d mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : conclude
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      err_total++;
      $display("mismatch at %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  // request held until ready is sampled high, bounded wait
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int k;
    k = 0;
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
      k++;
    end while (pready !== 1'b1 && k < 16);
    if (k >= 16) begin
      err_total++;
      conclude();
    end
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic rchk(input logic [11:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(rd, exp);
  endtask : rchk
  // covers sync flops plus registered outputs
  task automatic settle;
    repeat (6) @(posedge clk);
  endtask : settle
  task automatic row(input logic [15:0] s, c, input logic e, input logic [2:0] xr,
                     input logic [1:0] xm);
    apb(1'b1, ADDR_STATUS_ONE, {16'h0, s});
    apb(1'b1, ADDR_EXT_IFACE_CONFIG, {16'h0, c});
    apb(1'b1, ADDR_EXPANDER_CONTROL, {31'h0, e});
    settle();
    chk({29'h0, region}, {29'h0, xr});
    chk({30'h0, mode}, {30'h0, xm});
  endtask : row
  imvs_top i_dut (.clk(clk), .reset(reset), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .group_slot_input(slot_in), .boot_source_pin(boot_pin), .cpu_int_line(line),
    .group_winner(winner), .vector_base(vbase), .vector_region(region),
    .compat_mode(mode), .irq(irq));
  imvs_cpu_model i_cpu (.clk(clk), .reset(reset), .cpu_int_line(line),
    .group_winner(winner), .vector_base(vbase), .fetch_addr(fetch));
  // variant without the external interface: the pin must not reach the boot bit
  imvs_top #(.HAS_EXT_IFACE(1'b0)) i_dut_nx (.clk(clk), .reset(reset), .psel(1'b0),
    .penable(1'b0), .pwrite(1'b0), .paddr(12'h0), .pwdata(32'h0), .prdata(), .pready(),
    .pslverr(), .group_slot_input(96'h0), .boot_source_pin(boot_pin), .cpu_int_line(),
    .group_winner(), .vector_base(), .vector_region(region_nx), .compat_mode(), .irq());
  // ************************************
  // test sequence
  // ************************************
  initial begin
    repeat (8) @(posedge clk);
    reset <= 1'b0;
    rchk(ADDR_STATUS_ONE, 32'h808);
    rchk(ADDR_EXPANDER_CONTROL, 32'h0);
    apb(1'b0, ADDR_EXT_IFACE_CONFIG, 32'h0);
    chk(rd & 32'h100, 32'h100);
    chk({29'h0, region}, 32'h3);
    chk({29'h0, region_nx}, 32'h2);
    boot_pin <= 1'b0;  // pin no longer matters after reset
    settle();
    apb(1'b0, ADDR_EXT_IFACE_CONFIG, 32'h0);
    chk(rd & 32'h100, 32'h100);
    $display("test reset values done");
    row(16'h808, 16'h0, 1'b0, 3'h2, 2'h0);
    row(16'h808, 16'h100, 1'b0, 3'h3, 2'h0);
    row(16'h808, 16'h100, 1'b1, 3'h4, 2'h0);
    row(16'ha08, 16'h0, 1'b0, 3'h2, 2'h1);
    row(16'ha88, 16'h0, 1'b0, 3'h2, 2'h2);
    row(16'h888, 16'h0, 1'b0, 3'h2, 2'h3);
    row(16'h800, 16'h0, 1'b1, 3'h1, 2'h0);
    row(16'h0, 16'h0, 1'b0, 3'h0, 2'h0);
    apb(1'b1, ADDR_STATUS_ONE_SET, 32'h808);
    settle();
    chk({29'h0, region}, 32'h2);
    apb(1'b1, ADDR_STATUS_ONE_CLR, 32'h8);
    settle();
    chk({29'h0, region}, 32'h1);
    apb(1'b1, ADDR_STATUS_ONE_SET, 32'h8);
    $display("test region table done");
    apb(1'b1, ADDR_EXPANDER_CONTROL, 32'h1);
    apb(1'b1, ADDR_GROUP_EN_BASE, 32'hff);
    slot_in <= 96'h5;  // position 1 wired, position 3 reserved
    settle();
    chk({20'h0, line}, 32'h1);
    chk({10'h0, fetch}, 32'hd40);
    rchk(ADDR_GROUP_FLAG_BASE, 32'h1);
    slot_in <= 96'h0;
    apb(1'b1, ADDR_GROUP_FLAG_BASE, 32'h21);
    settle();
    chk({29'h0, winner[0]}, 32'h0);
    apb(1'b1, ADDR_GROUP_FLAG_BASE, 32'h20);
    settle();
    chk({29'h0, winner[0]}, 32'h5);
    apb(1'b1, ADDR_GROUP_FLAG_BASE, 32'h0);
    apb(1'b1, ADDR_GROUP_EN_BASE + 12'h2c, 32'h80);
    apb(1'b1, ADDR_GROUP_FLAG_BASE + 12'h2c, 32'h80);
    settle();
    chk({20'h0, line}, 32'h800);
    chk({10'h0, fetch}, 32'hdfe);
    $display("test group lines done");
    apb(1'b1, ADDR_IRQ_MASK, 32'h0);
    apb(1'b1, ADDR_IRQ_STATUS, 32'h3);
    apb(1'b1, ADDR_GROUP_FLAG_BASE, 32'h1);
    settle();
    chk({31'h0, irq}, 32'h0);
    apb(1'b1, ADDR_IRQ_MASK, 32'h1);
    settle();
    chk({31'h0, irq}, 32'h1);
    apb(1'b1, ADDR_IRQ_STATUS, 32'h3);
    settle();
    chk({31'h0, irq}, 32'h0);
    $display("test event interrupt done");
    apb(1'b1, ADDR_VECTOR_BASE + 12'h3fc, 32'h1234abcd);
    rchk(ADDR_VECTOR_BASE + 12'h3fc, 32'habcd);
    $display("test vector ram done");
    apb(1'b1, 12'hffc, 32'hffff);
    chk({31'h0, er}, 32'h1);
    rchk(12'hffc, 32'h0);
    chk({31'h0, er}, 32'h1);
    $display("test unmapped access done");
    conclude();
  end
endmodule : interrupt_mux_vector_select_tb
`default_nettype wire
